// *** inc/lsf_pkg.sv ***
// lsf_pkg: constants and carrier types for the laser start-up and fault shutdown block
// assumes a 40 MHz system clock; analog comparators deliver synchronous digital levels
package lsf_pkg;
  localparam int unsigned CLK_MHZ           = 40;
  localparam int unsigned INIT_US           = 50;
  localparam int unsigned INIT_CYC          = INIT_US * CLK_MHZ;
  localparam int unsigned GLITCH_US         = 10;
  localparam int unsigned GLITCH_CYC        = GLITCH_US * CLK_MHZ;
  localparam int unsigned TICK_US           = 500;
  localparam int unsigned TICK_CYC          = TICK_US * CLK_MHZ;
  localparam int unsigned CONV_MS           = 100;
  localparam int unsigned CONV_CYC          = CONV_MS * 1000 * CLK_MHZ;
  localparam int unsigned HOLD_MS           = 200;
  localparam int unsigned HOLD_CYC          = HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned NUM_FAULTS        = 5;
  localparam int unsigned FLT_SUPPLY        = 0;
  localparam int unsigned FLT_DIODE         = 1;
  localparam int unsigned FLT_BIAS          = 2;
  localparam int unsigned FLT_POWER         = 3;
  localparam int unsigned FLT_SAT           = 4;
  localparam logic [7:0]  BLANK_RESET       = 8'h01;

  // configuration bits, gathered as plain ports
  typedef struct packed {
    logic       output_enable;
    logic       shutdown_polarity_sel;
    logic       bias_drive_polarity;
    logic       mod_dac_reference;
    logic       feedback_polarity_flip;
    logic       power_loop_off;
    logic       los_comparator_off;
    logic       ext_fault_input_sel;
    logic       ext_fault_polarity;
    logic       soft_transmit_disable;
    logic [4:0] fault_source_mask;
    logic [7:0] saturation_blank_time;
  } lsf_cfg_t;

  // raw comparator outputs
  typedef struct packed {
    logic       rx_below_assert;
    logic       rx_above_release;
    logic [4:0] fault_raw;
  } lsf_cmp_t;

  // one pin driven as output, output enable and level
  typedef struct packed {
    logic o;
    logic oe;
  } lsf_pin_t;
endpackage : lsf_pkg

// *** hdl/lsf_deglitch.sv ***
// lsf_deglitch: passes a level only after it has held steady for a set number of cycles
// assumes input synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module lsf_deglitch #(
  parameter int unsigned CYCLES = 400
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // level in and filtered out
  input  wire logic din,
  output var  logic dout
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_dout;

  always_comb begin
    next_cnt  = '0;
    next_dout = dout;
    if (din != dout) begin
      if (cnt == CW'(CYCLES - 1)) begin
        next_dout = din;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt  <= '0;
      dout <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      dout <= next_dout;
    end
  end

  held_long_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(dout) |-> $past(din, 2)) else $error("filtered level rose without steady input");
endmodule : lsf_deglitch
`default_nettype wire

// *** hdl/lsf_top.sv ***
// lsf_top: laser start-up sequencing, fault latching and shutdown drive of laser outputs
// assumes analog comparators give digital levels synchronous to clk_sys and
// that configuration bits come from nonvolatile storage held outside this block
// What this block does
// - wait about 50 us after power-on before conversions, access and flags start
// - first measurement results ready one conversion period after initialization
// - output enable cleared keeps loop off and all three outputs floating
// - safety switch in shutdown: float if disabled, else level by polarity select
// - bias and modulation shutdown levels follow their reference bits, not flip
// - laser held off until hold delay, then loaded and loop started if enabled
// - outputs float as long as output enable stays cleared
// - disable asserted at power-up keeps drives shut down, conversions still run
// - any unmasked fault of five shuts the laser down and raises fault out
// - each of the five comparator fault sources is individually maskable by a persistent mask; the external fault input is not
// - saturation ignored for programmed blank time, 0.5 ms steps, after turn-on
// - loop saturation is an out-of-window compensation level, treated as fault
// - comparator fault paths ignore glitches shorter than about 10 us; the external fault input is not filtered
// - loss asserted below assert level, released only above release level
// - loss comparator can be turned off so an external part drives the pin
// - current loss pin level is reported in the status register
// - default shared pin is the safety switch, active when laser should be off
// - safety switch is push-pull with programmable active polarity
// - shared pin as external fault input, polarity selectable, ORed into fault
// - toggling transmit disable clears latched faults
// - power loop off bit switches the automatic loop, off from factory
`timescale 1ns/1ps
`default_nettype none
module lsf_top
  import lsf_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = lsf_pkg::INIT_CYC,
  parameter int unsigned CONV_CYCLES = lsf_pkg::CONV_CYC,
  parameter int unsigned HOLD_CYCLES = lsf_pkg::HOLD_CYC,
  parameter int unsigned TICK_CYCLES = lsf_pkg::TICK_CYC
) (
  // clock and reset
  input  wire  logic             clk_sys,
  input  wire  logic             rstn,
  // configuration and comparators
  input  wire  lsf_pkg::lsf_cfg_t cfg,
  input  wire  lsf_pkg::lsf_cmp_t cmp,
  // host module pins
  input  wire  logic             transmit_disable_in,
  output var   logic             transmit_fault_out,
  input  wire  logic             receive_signal_loss_i,
  output var   logic             receive_signal_loss_o,
  output var   logic             receive_signal_loss_oe,
  // shared pin: safety switch or external fault input
  input  wire  logic             laser_safety_switch_i,
  output var   lsf_pkg::lsf_pin_t laser_safety_switch,
  // laser drive
  output var   lsf_pkg::lsf_pin_t bias_drive_out,
  output var   lsf_pkg::lsf_pin_t mod_drive_out,
  output var   logic             laser_on,
  output var   logic             power_loop_run,
  output var   logic             dac_load,
  // status
  output var   logic             ready,
  output var   logic             power_on_flag,
  output var   logic             data_ready,
  output var   logic             conv_run,
  output var   logic [7:0]       control_status_reg
);
  import lsf_pkg::*;

  typedef enum logic [3:0] {
    LSF_INIT = 4'b0001,
    LSF_HOLD = 4'b0010,
    LSF_OFF  = 4'b0100,
    LSF_ON   = 4'b1000
  } lsf_state_t;

  localparam int unsigned SW = $clog2(HOLD_CYCLES + CONV_CYCLES + INIT_CYCLES + 1);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  // returns the level a drive shows in shutdown: float unless enabled
  function automatic lsf_pin_t shut_level(input logic en, input logic lvl);
    lsf_pin_t p;
    p.oe = en;
    p.o  = en & lvl;
    return p;
  endfunction : shut_level

  // filtered fault comparators
  logic [NUM_FAULTS-1:0] fault_f;
  genvar g;
  generate
    for (g = 0; g < NUM_FAULTS; g++) begin : g_flt
      lsf_deglitch #(.CYCLES(GLITCH_CYC)) u_dg (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .din     (cmp.fault_raw[g]),
        .dout    (fault_f[g])
      );
    end
  endgenerate

  lsf_state_t        state;
  lsf_state_t        next_state;
  logic [SW-1:0]     tmr;
  logic [SW-1:0]     next_tmr;
  logic [TW-1:0]     tick_cnt;
  logic [TW-1:0]     next_tick_cnt;
  logic [7:0]        blank_cnt;
  logic [7:0]        next_blank_cnt;
  logic              fault_latch;
  logic              next_fault_latch;
  logic              txd_q;
  logic              los;
  logic              next_los;
  logic              next_ready;
  logic              next_data_ready;
  logic              laser_req_on;
  logic              ext_fault;
  logic [NUM_FAULTS-1:0] fault_act;
  logic              sw_active;
  logic              blanking;
  logic              unmasked_hit;
  logic              other_hit;

  localparam logic [NUM_FAULTS-1:0] SAT_ONLY = NUM_FAULTS'(1) << FLT_SAT;

  // the pin reads back our own drive until its enable has dropped, so gate on that
  assign ext_fault = cfg.ext_fault_input_sel &
                     ~laser_safety_switch.oe &
                     (laser_safety_switch_i ^ ~cfg.ext_fault_polarity);
  always_comb begin
    fault_act = fault_f & ~cfg.fault_source_mask;
    if (blank_cnt != 8'h00) begin
      fault_act[FLT_SAT] = 1'b0;
    end
    if (state != LSF_ON) begin
      fault_act[FLT_SAT] = 1'b0;
    end
  end

  assign laser_req_on = !transmit_disable_in && !cfg.soft_transmit_disable;

  // start-up sequence
  always_comb begin
    next_state      = state;
    next_tmr        = tmr + 1'b1;
    next_ready      = ready;
    next_data_ready = data_ready;
    case (state)
      LSF_INIT: begin
        if (tmr == SW'(INIT_CYCLES - 1)) begin
          next_ready = 1'b1;
          next_tmr   = '0;
          next_state = LSF_HOLD;
        end
      end
      LSF_HOLD: begin
        if (tmr == SW'(CONV_CYCLES - 1)) begin
          next_data_ready = 1'b1;
        end
        if (tmr >= SW'(HOLD_CYCLES - 1)) begin
          next_tmr        = tmr;
          next_data_ready = 1'b1;
          next_state      = LSF_OFF;
        end
      end
      LSF_OFF: begin
        next_tmr = tmr;
        if (laser_req_on && !fault_latch) begin
          next_state = LSF_ON;
        end
      end
      LSF_ON: begin
        next_tmr = tmr;
        if (!laser_req_on || fault_latch || (|fault_act) || ext_fault) begin
          next_state = LSF_OFF;
        end
      end
      default: begin
        next_state = LSF_INIT;
        next_tmr   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state      <= LSF_INIT;
      tmr        <= '0;
      ready      <= 1'b0;
      data_ready <= 1'b0;
    end else begin
      state      <= next_state;
      tmr        <= next_tmr;
      ready      <= next_ready;
      data_ready <= next_data_ready;
    end
  end

  // saturation blanking, fixed 0.5 ms tick restarted at each turn-on
  always_comb begin
    next_tick_cnt  = tick_cnt;
    next_blank_cnt = blank_cnt;
    if (state != LSF_ON) begin
      next_tick_cnt  = '0;
      next_blank_cnt = cfg.saturation_blank_time;
    end else if (blank_cnt != 8'h00) begin
      if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
        next_tick_cnt  = '0;
        next_blank_cnt = blank_cnt - 8'h01;
      end else begin
        next_tick_cnt = tick_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt  <= '0;
      blank_cnt <= BLANK_RESET;
    end else begin
      tick_cnt  <= next_tick_cnt;
      blank_cnt <= next_blank_cnt;
    end
  end

  // fault latch: a new fault in the toggle cycle still wins
  always_comb begin
    next_fault_latch = fault_latch;
    if (transmit_disable_in != txd_q) begin
      next_fault_latch = 1'b0;
    end
    if (ready && ((|fault_act) || ext_fault)) begin
      next_fault_latch = 1'b1;
    end
  end

  // loss of signal with hysteresis, still tracked while the comparator output is off
  always_comb begin
    next_los = los;
    if (cmp.rx_below_assert) begin
      next_los = 1'b1;
    end else if (cmp.rx_above_release) begin
      next_los = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fault_latch <= 1'b0;
      txd_q       <= 1'b0;
      los         <= 1'b0;
    end else begin
      fault_latch <= next_fault_latch;
      txd_q       <= transmit_disable_in;
      los         <= next_los;
    end
  end

  // shutdown drive: active whenever the laser should be off
  assign sw_active = (state != LSF_ON) || next_state != LSF_ON;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      laser_safety_switch    <= '0;
      bias_drive_out         <= '0;
      mod_drive_out          <= '0;
      laser_on               <= 1'b0;
      power_loop_run         <= 1'b0;
      dac_load               <= 1'b0;
      transmit_fault_out     <= 1'b0;
      receive_signal_loss_o  <= 1'b0;
      receive_signal_loss_oe <= 1'b0;
      power_on_flag          <= 1'b0;
      conv_run               <= 1'b0;
      control_status_reg     <= 8'h00;
    end else begin
      if (cfg.ext_fault_input_sel) begin
        laser_safety_switch <= '0;
      end else if (sw_active) begin
        // push-pull; floats only with outputs disabled
        laser_safety_switch <= shut_level(cfg.output_enable,
                                          cfg.shutdown_polarity_sel);
      end else begin
        laser_safety_switch <= shut_level(cfg.output_enable,
                                          ~cfg.shutdown_polarity_sel);
      end
      if (sw_active) begin
        bias_drive_out <= shut_level(cfg.output_enable, cfg.bias_drive_polarity);
        mod_drive_out  <= shut_level(cfg.output_enable, cfg.mod_dac_reference);
      end else begin
        // analog level set by the dacs; enable gates a level opposite to the shutdown bit
        bias_drive_out <= shut_level(cfg.output_enable, ~cfg.bias_drive_polarity);
        mod_drive_out  <= shut_level(cfg.output_enable, ~cfg.mod_dac_reference);
      end
      laser_on       <= !sw_active && cfg.output_enable;
      power_loop_run <= !sw_active && cfg.output_enable && !cfg.power_loop_off;
      dac_load       <= (state == LSF_OFF) && (next_state == LSF_ON);
      transmit_fault_out <= next_fault_latch;
      receive_signal_loss_o  <= los;
      receive_signal_loss_oe <= !cfg.los_comparator_off;
      power_on_flag  <= next_ready;
      conv_run       <= next_ready;
      control_status_reg <= {3'b000, cfg.soft_transmit_disable, transmit_disable_in,
                             next_fault_latch, receive_signal_loss_i, next_data_ready};
    end
  end

  // assertion helpers: fault sources as seen ahead of the latch logic
  assign blanking     = (blank_cnt != 8'h00);
  assign unmasked_hit = ext_fault || (|(fault_f & ~cfg.fault_source_mask));
  assign other_hit    = ext_fault ||
                        (|(fault_f & ~cfg.fault_source_mask & ~SAT_ONLY));

  float_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !$past(cfg.output_enable) |-> !bias_drive_out.oe && !mod_drive_out.oe
                                   && !laser_safety_switch.oe)
    else $error("drive enabled while output enable cleared");
  fault_latch_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    transmit_fault_out && $stable(transmit_disable_in) |=> transmit_fault_out)
    else $error("fault dropped without toggle");
  fault_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    fault_latch |=> !laser_on)
    else $error("laser on with latched fault");
  init_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(ready) |-> $past(state == LSF_INIT))
    else $error("ready outside init");
  sequence txd_held_s;
    transmit_disable_in ##1 transmit_disable_in;
  endsequence : txd_held_s
  txd_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    txd_held_s |=> !laser_on)
    else $error("laser on while disabled");
  los_hyst_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(los) |-> $past(cmp.rx_above_release) && !$past(cmp.rx_below_assert))
    else $error("loss released without release level");
  blank_sat_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    blanking && !other_hit |=> !$rose(fault_latch))
    else $error("saturation acted during blanking");
  mask_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(fault_latch) |-> $past(unmasked_hit))
    else $error("masked fault acted");
  dac_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    dac_load |=> !dac_load)
    else $error("dac load longer than one cycle");
endmodule : lsf_top
`default_nettype wire

// *** test/lsf_far_model.sv ***
// lsf_far_model: host board and external laser driver seen from the shared and loss pins
// assumes the bench commands when the far side drives either pin
`timescale 1ns/1ps
`default_nettype none
module lsf_far_model
  import lsf_pkg::*;
(
  // clock
  input  wire logic              clk_sys,
  // device side of the pins
  input  wire lsf_pkg::lsf_pin_t laser_safety_switch,
  input  wire logic              receive_signal_loss_o,
  input  wire logic              receive_signal_loss_oe,
  // bench commands
  input  wire logic              ext_fault_drive,
  input  wire logic              ext_fault_level,
  input  wire logic              ext_los_drive,
  input  wire logic              ext_los_level,
  // resolved wire levels
  output var  logic              laser_safety_switch_i,
  output var  logic              receive_signal_loss_i
);
  logic idle_pattern = 1'b0;
  // a floating shared pin changes every cycle so no stale level can pass for a drive
  always @(posedge clk_sys) idle_pattern <= ~idle_pattern;
  always_comb begin
    if (laser_safety_switch.oe) begin
      laser_safety_switch_i = laser_safety_switch.o;
    end else if (ext_fault_drive) begin
      laser_safety_switch_i = ext_fault_level;
    end else begin
      laser_safety_switch_i = idle_pattern;
    end
    // loss line has a host pull-up
    if (receive_signal_loss_oe) begin
      receive_signal_loss_i = receive_signal_loss_o;
    end else if (ext_los_drive) begin
      receive_signal_loss_i = ext_los_level;
    end else begin
      receive_signal_loss_i = 1'b1;
    end
  end
endmodule : lsf_far_model
`default_nettype wire

// *** test/lsf_top_bench.sv ***
// lsf_top_bench: self-checking bench for lsf_top with shortened counts
// assumes lsf_far_model resolves the shared and loss pins
`timescale 1ns/1ps
`default_nettype none
module lsf_top_bench;
  import lsf_pkg::*;
  localparam int unsigned INIT = 20;
  localparam int unsigned CONV = 30;
  localparam int unsigned HOLD = 60;
  localparam int unsigned TICK = 10;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  lsf_cfg_t   cfg;
  lsf_cmp_t   cmp;
  logic       tx_dis, ef_drv, ef_lvl, el_drv, el_lvl, ss_i, los_i, los_o, los_oe;
  logic       fault, laser_on, loop_run, dac_load, ready, por, data_ready, conv_run;
  lsf_pin_t   ss, bias, mod;
  logic [7:0] csr;
  int         fails = 0;
  int         comparisons = 0;
  int         cycles = 0;
  int         loads = 0;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (dac_load === 1'b1) loads <= loads + 1;
    // whole run needs about 14000 cycles
    if (cycles == 40000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  lsf_top #(.INIT_CYCLES(INIT), .CONV_CYCLES(CONV), .HOLD_CYCLES(HOLD), .TICK_CYCLES(TICK))
  lsf_top_i (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .cmp(cmp),
    .transmit_disable_in(tx_dis), .transmit_fault_out(fault), .receive_signal_loss_i(los_i),
    .receive_signal_loss_o(los_o), .receive_signal_loss_oe(los_oe),
    .laser_safety_switch_i(ss_i), .laser_safety_switch(ss), .bias_drive_out(bias),
    .mod_drive_out(mod), .laser_on(laser_on), .power_loop_run(loop_run), .dac_load(dac_load),
    .ready(ready), .power_on_flag(por), .data_ready(data_ready), .conv_run(conv_run),
    .control_status_reg(csr));
  lsf_far_model lsf_far_model_i (.clk_sys(clk_sys), .laser_safety_switch(ss),
    .receive_signal_loss_o(los_o), .receive_signal_loss_oe(los_oe), .ext_fault_drive(ef_drv),
    .ext_fault_level(ef_lvl), .ext_los_drive(el_drv), .ext_los_level(el_lvl),
    .laser_safety_switch_i(ss_i), .receive_signal_loss_i(los_i));
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic power_up(input logic dis);
    rstn <= 1'b0;
    tx_dis <= dis;
    tick(8);
    rstn <= 1'b1;
  endtask : power_up
  // toggles transmit disable to clear a latched fault
  task automatic clear_fault;
    tick(1);
    tx_dis <= 1'b1;
    tick(3);
    tx_dis <= 1'b0;
    tick(10);
  endtask : clear_fault
  task automatic t_init;
    power_up(1'b0);
    tick(INIT - 4);
    check({ready, por, conv_run}, 3'b000);
    tick(8);
    check({ready, por, conv_run, data_ready}, 4'b1110);
    tick(CONV);
    check({data_ready, csr[0]}, 2'b11);
    tick(HOLD);
    check({ss.oe, bias.oe, mod.oe, loop_run}, 4'b0000);
  endtask : t_init
  task automatic t_levels;
    cfg.output_enable <= 1'b1;
    power_up(1'b1);
    tick(INIT + HOLD + 10);
    check({laser_on, conv_run, csr[3]}, 3'b011);
    for (int k = 0; k < 16; k++) begin
      tick(1);
      cfg.shutdown_polarity_sel <= k[0];
      cfg.bias_drive_polarity <= k[1];
      cfg.mod_dac_reference <= k[2];
      cfg.feedback_polarity_flip <= k[3];
      tick(3);
      check(ss, {k[0], 1'b1});
      check({bias, mod}, {k[1], 1'b1, k[2], 1'b1});
    end
    tick(1);
    cfg.output_enable <= 1'b0;
    tick(3);
    check({ss.oe, bias.oe, mod.oe}, 3'b000);
  endtask : t_levels
  task automatic t_turn_on;
    int base;
    cfg <= '0;
    tick(1);
    cfg.output_enable <= 1'b1;
    cfg.saturation_blank_time <= 8'h01;
    base = loads;
    power_up(1'b0);
    tick(INIT + HOLD - 5);
    check(laser_on, 1'b0);
    tick(10);
    check({laser_on, loop_run, ss, bias, mod}, 8'hff);
    check(loads - base, 1);
    cfg.power_loop_off <= 1'b1;
    tick(3);
    check(loop_run, 1'b0);
    cfg.power_loop_off <= 1'b0;
    cfg.soft_transmit_disable <= 1'b1;
    tick(3);
    check({laser_on, ss, csr[4]}, 4'b0011);
    cfg.soft_transmit_disable <= 1'b0;
    tick(5);
    check(laser_on, 1'b1);
  endtask : t_turn_on
  task automatic t_fault(input int i);
    cmp.fault_raw[i] <= 1'b1;
    tick(300);
    cmp.fault_raw[i] <= 1'b0;
    tick(120);
    check(fault, 1'b0);
    cfg.fault_source_mask[i] <= 1'b1;
    cmp.fault_raw[i] <= 1'b1;
    tick(450);
    check(fault, 1'b0);
    cmp.fault_raw[i] <= 1'b0;
    tick(420);
    cfg.fault_source_mask[i] <= 1'b0;
    cmp.fault_raw[i] <= 1'b1;
    tick(390);
    check(fault, 1'b0);
    tick(20);
    check({fault, laser_on, ss, csr[2]}, 5'b10011);
    cmp.fault_raw[i] <= 1'b0;
    tick(420);
    check({fault, laser_on}, 2'b10);
    clear_fault();
    check({fault, laser_on}, 2'b01);
  endtask : t_fault
  task automatic t_sat;
    cfg.saturation_blank_time <= 8'h50;
    tx_dis <= 1'b1;
    tick(3);
    cmp.fault_raw[FLT_SAT] <= 1'b1;
    tx_dis <= 1'b0;
    tick(600);
    check({fault, laser_on}, 2'b01);
    tick(300);
    check({fault, laser_on}, 2'b10);
    cmp.fault_raw[FLT_SAT] <= 1'b0;
    tick(420);
    clear_fault();
    check(fault, 1'b0);
  endtask : t_sat
  task automatic t_ext;
    tick(1);
    cfg.ext_fault_input_sel <= 1'b1;
    cfg.ext_fault_polarity <= 1'b1;
    tick(3);
    check(ss.oe, 1'b0);
    for (int p = 1; p >= 0; p--) begin
      cfg.ext_fault_polarity <= p[0];
      ef_lvl <= ~p[0];
      tick(420);
      check(fault, 1'b0);
      ef_lvl <= p[0];
      tick(420);
      check({fault, csr[2]}, 2'b11);
      ef_lvl <= ~p[0];
      tick(420);
      clear_fault();
    end
    cfg.ext_fault_input_sel <= 1'b0;
  endtask : t_ext
  task automatic t_los;
    tick(1);
    cmp.rx_below_assert <= 1'b1;
    tick(420);
    check({los_o, los_oe, csr[1]}, 3'b111);
    cmp.rx_below_assert <= 1'b0;
    tick(420);
    check(los_o, 1'b1);
    cmp.rx_above_release <= 1'b1;
    tick(420);
    check({los_o, csr[1]}, 2'b00);
    cfg.los_comparator_off <= 1'b1;
    el_drv <= 1'b1;
    el_lvl <= 1'b1;
    tick(5);
    check({los_oe, csr[1]}, 2'b01);
    el_lvl <= 1'b0;
    tick(5);
    check(csr[1], 1'b0);
  endtask : t_los
  initial begin
    cfg = '0;
    cmp = '0;
    tx_dis = 1'b0;
    ef_drv = 1'b1;
    ef_lvl = 1'b0;
    el_drv = 1'b0;
    el_lvl = 1'b0;
    t_init();
    t_levels();
    t_turn_on();
    for (int i = 0; i < 4; i++) t_fault(i);
    t_sat();
    t_ext();
    t_los();
    report_and_stop();
  end
endmodule : lsf_top_bench
`default_nettype wire
